/* rtl/lcdc_defs.vh */
// Constants for the LCD display core: timing counts, modes and reset values.
// Assumes a 100 MHz mclk; included by the core by bare name.
`ifndef LCDC_DEFS_VH
`define LCDC_DEFS_VH
// Clock rate and display oscillator model
`define LCDC_MCLK_HZ        100000000
`define LCDC_OSC_HZ         32768
`define LCDC_OSC_DIV        (`LCDC_MCLK_HZ / `LCDC_OSC_HZ)
// Frame rate selection codes
`define LCDC_FR_64          2'h0
`define LCDC_FR_85          2'h1
`define LCDC_FR_128         2'h2
`define LCDC_FR_170         2'h3
// Oscillator ticks per common phase for each frame rate (frame = 4 phases)
`define LCDC_PH_64          8'h80
`define LCDC_PH_85          8'h60
`define LCDC_PH_128         8'h40
`define LCDC_PH_170         8'h30
// Blink codes and half periods in oscillator ticks
`define LCDC_BL_OFF         2'h0
`define LCDC_BL_2HZ         2'h1
`define LCDC_BL_1HZ         2'h2
`define LCDC_BL_05HZ        2'h3
`define LCDC_BLH_2HZ        16'h2000
`define LCDC_BLH_1HZ        16'h4000
`define LCDC_BLH_05HZ       16'h8000
// Drive modes: maximum address per mode
`define LCDC_MAX_32         4'hF
`define LCDC_MAX_28         4'hD
`define LCDC_MAX_24         4'hB
// Bias select values
`define LCDC_BIAS_THIRD     1'b1
`define LCDC_BIAS_HALF      1'b0
// Drive level codes for each output line (2 bits)
`define LCDC_LVL_VSS        2'h0
`define LCDC_LVL_LO         2'h1
`define LCDC_LVL_HI         2'h2
`define LCDC_LVL_LCD_SUPPLY_PIN       2'h3
// Host interface wait after reset, in ms
`define LCDC_RST_WAIT_MS    1
`endif

/* rtl/lcdc_core.v */
// LCD display core: 32x4 display memory, common/segment scan, LED sinks.
// Assumes a command decoder feeds the strobes below synchronously to mclk.
// Operation
// [RULE1] Power-on selects 1/3 bias, oscillator and bias generator stopped, display off.
// [RULE2] Power-on disables the regulator and enables internal voltage adjust.
// [RULE3] Every reset sets 64Hz frame rate, blink off, shared lines as segments.
// [RULE4] Low external reset restores all the same defaults as power-on; the code keeps iva_en_q, iva_level_q and led_q.
// [RULE5] Either reset drives all commons and segments to the lcd supply level.
// [RULE6] Display memory is 32x4 static bits; one lights a segment, zero darkens.
// [RULE7] Memory columns 0..3 drive segments during common phases 0..3.
// [RULE8] Byte N holds segment 2N in bits 3..0, segment 2N+1 in bits 7..4.
// [RULE9] LED data bit 7 controls LED7 down to bit 0 controlling LED0.
// [RULE10] Share-high bit clear: 32 segments, addresses 00H to 0FH, reset default.
// [RULE11] Share-high set, share-low clear: 28 segments plus 4 LEDs, to 0DH.
// [RULE12] Both share bits set: 24 segments plus 8 LEDs, addresses to 0BH.
// [RULE13] Internal oscillator times logic and waveforms, starts stopped.
// [RULE14] Full-scale voltage from supply pin or regulator set by voltage adjust.
// [RULE15] Half bias switches centre divider resistor out; third bias keeps all four.
// [RULE16] Frame rate selectable among 64, 85.3, 128 and 170.6 Hz.
// [RULE17] Commons scanned at 1/4 duty, one active per quarter frame.
// [RULE18] Data-input command loads pointer; one or many bytes stored from there.
// [RULE19] Enabled blinking flashes the whole display at a divided oscillator rate.
// [RULE20] Host waits at least 1 ms after reset before serial transfers.
// [RULE21] Blink codes 0..3 mean off, 2Hz, 1Hz, 0.5Hz.
// [RULE22] Pointer increments after each byte and wraps to zero past mode maximum.
// [RULE23] LED bit one turns its open-drain sink on; zero turns it off.
// [RULE24] Display off or oscillator stopped holds lines at reset level, keeps memory.
// [RULE25] Lines assigned as LEDs follow LED data, ignoring display memory.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "lcdc_defs.vh"
module lcdc_core (
   // Clock and resets
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire        external_reset_low,

   // Command side
   input  wire        cmd_ptr_load,
   input  wire [3:0]  cmd_ptr_addr,
   input  wire        cmd_data_wr,
   input  wire [7:0]  cmd_data,
   input  wire        cmd_mode_wr,
   input  wire        led_share_hi_bit,
   input  wire        led_share_lo_bit,
   input  wire        cmd_sys_wr,
   input  wire        cmd_osc_on,
   input  wire        cmd_disp_on,
   input  wire        cmd_bias_third,
   input  wire        cmd_frame_wr,
   input  wire [1:0]  cmd_frame_sel,
   input  wire        cmd_blink_wr,
   input  wire [1:0]  cmd_blink_sel,
   input  wire        cmd_reg_wr,
   input  wire        cmd_reg_en,
   input  wire        cmd_iva_en,
   input  wire [2:0]  cmd_iva_level,
   input  wire        cmd_led_wr,
   input  wire [7:0]  cmd_led_data,
   input  wire        cmd_rd,

   // Readback
   output reg  [7:0]  rd_data_q,
   output reg  [3:0]  ptr_q,

   // Panel drive, two level bits per common and segment line, one bit per LED sink
   output reg  [7:0]  common_drive_lines,
   output reg  [63:0] segment_drive_lines,
   output reg  [7:0]  led_sink_outputs,

   // Analog controls
   output reg         bias_third_q,
   output reg         bias_gen_on_q,
   output reg         reg_en_q,
   output reg         iva_en_q,
   output reg  [2:0]  iva_level_q,
   output reg         osc_on_q,
   output reg         disp_on_q
);
   // Control state
   reg  [1:0]  frame_sel_q;
   reg  [1:0]  blink_sel_q;
   reg  [1:0]  mode_q;
   reg  [7:0]  led_q;

   // Display memory, one nibble per segment
   reg  [3:0]  mem_q [0:31];

   // Oscillator, common scan and blink timing
   reg  [15:0] osc_cnt_q;
   reg         tick_q;
   reg  [7:0]  ph_cnt_q;
   reg  [1:0]  com_q;
   reg         inv_q;
   reg  [15:0] blk_cnt_q;
   reg         blk_off_q;

   // Reset and derived values
   reg         ext_q;
   wire        rst_any;
   reg  [3:0]  max_addr;
   reg  [7:0]  ph_len;
   reg  [15:0] blk_half;
   reg  [7:0]  led_en;
   wire        drive_on;
   reg  [3:0]  ptr_d;

   // Last divider count, cut to the counter width
   localparam [31:0] OSC_LAST_W = `LCDC_OSC_DIV - 1;
   localparam [15:0] OSC_LAST   = OSC_LAST_W[15:0];

   // External reset is synchronised and resets all but the voltage adjust, LED data and display memory
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         ext_q <= 1'b1;
      else
         ext_q <= ~external_reset_low; // RULE4
   end

   // Reset from the pin, one clock of latency
   assign rst_any = ext_q;

   // Mode maximum address
   always @* begin
      case (mode_q)
         2'h3:    max_addr = `LCDC_MAX_24; // RULE12
         2'h2:    max_addr = `LCDC_MAX_28; // RULE11
         default: max_addr = `LCDC_MAX_32; // RULE10
      endcase
   end

   // Phase length per frame rate
   always @* begin
      case (frame_sel_q)
         `LCDC_FR_85:  ph_len = `LCDC_PH_85; // RULE16
         `LCDC_FR_128: ph_len = `LCDC_PH_128;
         `LCDC_FR_170: ph_len = `LCDC_PH_170;
         default:      ph_len = `LCDC_PH_64;
      endcase
   end

   // Blink half period in oscillator ticks
   always @* begin
      case (blink_sel_q)
         `LCDC_BL_2HZ: blk_half = `LCDC_BLH_2HZ; // RULE21
         `LCDC_BL_1HZ: blk_half = `LCDC_BLH_1HZ;
         default:      blk_half = `LCDC_BLH_05HZ;
      endcase
   end

   // LED sinks enabled by the drive mode
   always @* begin
      case (mode_q)
         2'h3:    led_en = 8'hFF;
         2'h2:    led_en = 8'h0F;
         default: led_en = 8'h00;
      endcase
   end

   // Panel driven only with oscillator and display both on
   assign drive_on = osc_on_q & disp_on_q; // RULE24

   // Power, display and bias controls
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         bias_third_q  <= `LCDC_BIAS_THIRD; // RULE1
         bias_gen_on_q <= 1'b0;
         osc_on_q      <= 1'b0;             // RULE13
         disp_on_q     <= 1'b0;
      end else if (rst_any) begin
         bias_third_q  <= `LCDC_BIAS_THIRD; // RULE4
         bias_gen_on_q <= 1'b0;
         osc_on_q      <= 1'b0;
         disp_on_q     <= 1'b0;
      end else if (cmd_sys_wr) begin
         osc_on_q      <= cmd_osc_on;
         bias_gen_on_q <= cmd_osc_on & cmd_disp_on;
         disp_on_q     <= cmd_disp_on;
         bias_third_q  <= cmd_bias_third;   // RULE15
      end
   end

   // Regulator and voltage adjust; pin reset keeps the adjust setting
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_en_q    <= 1'b0; // RULE2
         iva_en_q    <= 1'b1;
         iva_level_q <= 3'h0;
      end else if (rst_any) begin
         reg_en_q    <= 1'b0;
      end else if (cmd_reg_wr) begin
         reg_en_q    <= cmd_reg_en; // RULE14
         iva_en_q    <= cmd_iva_en;
         iva_level_q <= cmd_iva_level;
      end
   end

   // Frame rate and blink selects
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_sel_q <= `LCDC_FR_64; // RULE3
         blink_sel_q <= `LCDC_BL_OFF;
      end else if (rst_any) begin
         frame_sel_q <= `LCDC_FR_64;
         blink_sel_q <= `LCDC_BL_OFF;
      end else begin
         if (cmd_frame_wr)
            frame_sel_q <= cmd_frame_sel;
         if (cmd_blink_wr)
            blink_sel_q <= cmd_blink_sel;
      end
   end

   // Drive mode and LED data
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q <= 2'h0;
         led_q  <= 8'h00;
      end else if (rst_any) begin
         mode_q <= 2'h0;
      end else begin
         if (cmd_mode_wr)
            mode_q <= {led_share_hi_bit, led_share_hi_bit & led_share_lo_bit};
         if (cmd_led_wr)
            led_q <= cmd_led_data; // RULE9
      end
   end

   // Pointer next value
   always @* begin
      ptr_d = ptr_q;
      if (cmd_ptr_load) begin
         if (cmd_ptr_addr > max_addr)
            ptr_d = 4'h0; // Out of range loads land on zero
         else
            ptr_d = cmd_ptr_addr; // RULE18
      end else if (cmd_data_wr | cmd_rd) begin
         if (ptr_q >= max_addr)
            ptr_d = 4'h0; // RULE22
         else
            ptr_d = ptr_q + 4'h1;
      end
   end

   // Address pointer
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         ptr_q <= 4'h0;
      else if (rst_any)
         ptr_q <= 4'h0;
      else
         ptr_q <= ptr_d;
   end

   // Readback byte, updated by each read strobe
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         rd_data_q <= 8'h00;
      else if (rst_any)
         rd_data_q <= 8'h00;
      else if (cmd_rd)
         rd_data_q <= {mem_q[{ptr_q, 1'b1}], mem_q[{ptr_q, 1'b0}]}; // RULE8
   end

   // Display memory: kept across resets and display off
   always @(posedge mclk) begin
      if (cmd_data_wr & ~rst_any) begin
         mem_q[{ptr_q, 1'b0}] <= cmd_data[3:0]; // RULE8
         mem_q[{ptr_q, 1'b1}] <= cmd_data[7:4]; // RULE6
      end
   end

   // Oscillator model: tick at the display oscillator rate
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         osc_cnt_q <= 16'h0000;
         tick_q    <= 1'b0;
      end else if (rst_any | ~osc_on_q) begin
         osc_cnt_q <= 16'h0000; // RULE13
         tick_q    <= 1'b0;
      end else if (osc_cnt_q == OSC_LAST) begin
         osc_cnt_q <= 16'h0000;
         tick_q    <= 1'b1;
      end else begin
         osc_cnt_q <= osc_cnt_q + 16'h0001;
         tick_q    <= 1'b0;
      end
   end

   // Common scan: each phase split into two polarity halves to keep drive AC
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ph_cnt_q <= 8'h00;
         com_q    <= 2'h0;
         inv_q    <= 1'b0;
      end else if (rst_any | ~osc_on_q) begin
         ph_cnt_q <= 8'h00;
         com_q    <= 2'h0;
         inv_q    <= 1'b0;
      end else if (tick_q) begin
         if (ph_cnt_q >= ph_len - 8'h02) begin // Counts by two: half a phase
            ph_cnt_q <= 8'h00;
            inv_q    <= ~inv_q;
            if (inv_q)
               com_q <= com_q + 2'h1; // RULE17
         end else begin
            ph_cnt_q <= ph_cnt_q + 8'h02;
         end
      end
   end

   // Blink timer: whole display dark on alternate half periods
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         blk_cnt_q <= 16'h0000;
         blk_off_q <= 1'b0;
      end else if (rst_any | ~osc_on_q | (blink_sel_q == `LCDC_BL_OFF)) begin
         blk_cnt_q <= 16'h0000;
         blk_off_q <= 1'b0;
      end else if (tick_q) begin
         if (blk_cnt_q >= blk_half - 16'h0001) begin
            blk_cnt_q <= 16'h0000;
            blk_off_q <= ~blk_off_q; // RULE19
         end else begin
            blk_cnt_q <= blk_cnt_q + 16'h0001;
         end
      end
   end

   // Output drive levels
   genvar s;

   generate
      for (s = 0; s < 32; s = s + 1) begin : g_seg
         wire is_led = (s >= 28 && mode_q[1]) || (s >= 24 && mode_q == 2'h3);
         wire on_bit = mem_q[s][com_q] & ~blk_off_q; // RULE7
         // Lit segment opposes the active common; dark one sits at a mid level
         always @(posedge mclk or posedge sys_rst) begin
            if (sys_rst)
               segment_drive_lines[2*s+1:2*s] <= `LCDC_LVL_LCD_SUPPLY_PIN; // RULE5
            else if (rst_any | ~drive_on | is_led)
               segment_drive_lines[2*s+1:2*s] <= `LCDC_LVL_LCD_SUPPLY_PIN; // RULE25
            else begin
               case ({on_bit, inv_q})
                  2'b10:   segment_drive_lines[2*s+1:2*s] <= `LCDC_LVL_VSS;
                  2'b11:   segment_drive_lines[2*s+1:2*s] <= `LCDC_LVL_LCD_SUPPLY_PIN;
                  2'b01:   segment_drive_lines[2*s+1:2*s] <= `LCDC_LVL_LO;
                  default: segment_drive_lines[2*s+1:2*s] <= `LCDC_LVL_HI;
               endcase
            end
         end
      end

      for (s = 0; s < 4; s = s + 1) begin : g_com
         // Active common swings full; idle commons sit at mid levels
         always @(posedge mclk or posedge sys_rst) begin
            if (sys_rst)
               common_drive_lines[2*s+1:2*s] <= `LCDC_LVL_LCD_SUPPLY_PIN; // RULE5
            else if (rst_any | ~drive_on)
               common_drive_lines[2*s+1:2*s] <= `LCDC_LVL_LCD_SUPPLY_PIN; // RULE24
            else begin
               case ({com_q == s, inv_q})
                  2'b10:   common_drive_lines[2*s+1:2*s] <= `LCDC_LVL_LCD_SUPPLY_PIN;
                  2'b11:   common_drive_lines[2*s+1:2*s] <= `LCDC_LVL_VSS;
                  2'b01:   common_drive_lines[2*s+1:2*s] <= `LCDC_LVL_HI;
                  default: common_drive_lines[2*s+1:2*s] <= `LCDC_LVL_LO;
               endcase
            end
         end
      end

      for (s = 0; s < 8; s = s + 1) begin : g_led
         // Segment 24+k carries LED(7-k)
         always @(posedge mclk or posedge sys_rst) begin
            if (sys_rst)
               led_sink_outputs[s] <= 1'b0;
            else if (rst_any)
               led_sink_outputs[s] <= 1'b0;
            else
               led_sink_outputs[s] <= led_q[s] & led_en[s]; // RULE23
         end
      end
   endgenerate
endmodule // lcdc_core

/* tb/lcdc_props.sv */
// Checker for the LCD core: reset defaults, pointer, scan and LED sharing.
// Bound to lcdc_core below; sees its ports only.
`timescale 1ns/1ps
module lcdc_props (
   // Clock and resets
   input wire        mclk,
   input wire        sys_rst,
   input wire        external_reset_low,
   // Command side
   input wire        cmd_ptr_load,
   input wire [3:0]  cmd_ptr_addr,
   input wire        cmd_data_wr,
   input wire        cmd_mode_wr,
   input wire        led_share_hi_bit,
   input wire        led_share_lo_bit,
   // Outputs watched
   input wire [3:0]  ptr_q,
   input wire [7:0]  common_drive_lines,
   input wire [63:0] segment_drive_lines,
   input wire [7:0]  led_sink_outputs,
   input wire        bias_third_q,
   input wire        reg_en_q,
   input wire        osc_on_q,
   input wire        disp_on_q
);
   reg  [1:0] mode_q;
   reg        ext_ok_q;
   wire       wr_ok = cmd_data_wr && !cmd_ptr_load && ext_ok_q;
   wire [3:0] max_addr = mode_q[1] ? (mode_q[0] ? 4'hB : 4'hD) : 4'hF;
   // Commons sitting at an outer level: both code bits equal
   wire [3:0] com_out = ~({common_drive_lines[7], common_drive_lines[5], common_drive_lines[3],
                          common_drive_lines[1]} ^ {common_drive_lines[6], common_drive_lines[4],
                          common_drive_lines[2], common_drive_lines[0]});
   // Pin reset reaches the core one clock late
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) ext_ok_q <= 1'b0;
      else ext_ok_q <= external_reset_low;
   end
   // Drive mode as last commanded
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst || !ext_ok_q) mode_q <= 2'h0;
      else if (cmd_mode_wr) mode_q <= {led_share_hi_bit, led_share_lo_bit};
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_ext_dflt; !external_reset_low |-> ##2 (bias_third_q && !osc_on_q && !disp_on_q
      && !reg_en_q); endproperty
   a_ext_dflt: assert property (p_ext_dflt) else $error("external reset defaults");
   property p_ext_lines; !external_reset_low |-> ##3 (&common_drive_lines
      && &segment_drive_lines); endproperty
   a_ext_lines: assert property (p_ext_lines) else $error("lines not at supply");
   property p_off_idle; !disp_on_q |=> &common_drive_lines && &segment_drive_lines; endproperty
   a_off_idle: assert property (p_off_idle) else $error("lines move while off");
   property p_ptr_inc; wr_ok && ptr_q < 4'hB |=> ptr_q == $past(ptr_q) + 4'h1; endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not step");
   property p_ptr_wrap; wr_ok && ptr_q == max_addr |=> ptr_q == 4'h0; endproperty
   a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");
   property p_ptr_load; cmd_ptr_load && ext_ok_q && cmd_ptr_addr <= max_addr
      |=> ptr_q == $past(cmd_ptr_addr); endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("pointer load wrong");
   property p_duty; (disp_on_q && osc_on_q) [*3] ##0 common_drive_lines != 8'hFF
      |-> $onehot(com_out); endproperty
   a_duty: assert property (p_duty) else $error("not one common active");
   property p_led_seg; mode_q[1] [*2] |=> &segment_drive_lines[63:56]; endproperty
   a_led_seg: assert property (p_led_seg) else $error("LED line drives segment");
   property p_led_off; !mode_q[1] [*2] |=> led_sink_outputs == 8'h00; endproperty
   a_led_off: assert property (p_led_off) else $error("LED sink on in 32 mode");
   c_scan: cover property (disp_on_q && common_drive_lines != 8'hFF);
   c_wrap: cover property (wr_ok && ptr_q == max_addr);
   c_leds: cover property (mode_q == 2'h3 && led_sink_outputs != 8'h00);
endmodule // lcdc_props
bind lcdc_core lcdc_props chk_u (.mclk, .sys_rst, .external_reset_low, .cmd_ptr_load,
   .cmd_ptr_addr, .cmd_data_wr, .cmd_mode_wr, .led_share_hi_bit, .led_share_lo_bit, .ptr_q,
   .common_drive_lines, .segment_drive_lines, .led_sink_outputs, .bias_third_q, .reg_en_q,
   .osc_on_q, .disp_on_q);

/* tb/lcdc_panel.sv */
// Panel model: LED indicators and the COM0 pixel row of the glass.
// Assumes the two-bit level codes of the core on every common and segment line.
`timescale 1ns/1ps
module lcdc_panel (
   // Lines from the core
   input  wire [7:0]  common_drive_lines,
   input  wire [63:0] segment_drive_lines,
   input  wire [7:0]  led_sink_outputs,
   // What the viewer sees
   output wire [7:0]  led_lit,
   output reg  [31:0] pix_com0
);
   integer s;
   // An LED glows while its sink draws current
   assign led_lit = led_sink_outputs;
   // Full swing against COM0 lights a pixel
   always @* begin
      for (s = 0; s < 32; s = s + 1)
         pix_com0[s] = segment_drive_lines[2*s +: 2] == ~common_drive_lines[1:0];
   end
endmodule // lcdc_panel

/* tb/testbench.sv */
// Testbench for the LCD core: resets, memory map, drive modes, scan start.
// Drives one command strobe at a time; panel model decodes the glass.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module testbench;
   reg         mclk = 0, sys_rst = 1, external_reset_low = 1, cmd_rd = 0;
   reg         cmd_ptr_load = 0, cmd_data_wr = 0, cmd_mode_wr = 0, cmd_sys_wr = 0;
   reg         cmd_frame_wr = 0, cmd_blink_wr = 0, cmd_reg_wr = 0, cmd_led_wr = 0;
   reg         led_share_hi_bit = 0, led_share_lo_bit = 0, cmd_osc_on = 0, cmd_disp_on = 0;
   reg         cmd_bias_third = 0, cmd_reg_en = 0, cmd_iva_en = 0;
   reg  [3:0]  cmd_ptr_addr = 0;
   reg  [7:0]  cmd_data = 0, cmd_led_data = 0;
   reg  [1:0]  cmd_frame_sel = 0, cmd_blink_sel = 0;
   reg  [2:0]  cmd_iva_level = 0;
   wire [7:0]  rd_data_q, common_drive_lines, led_sink_outputs, led_lit;
   wire [63:0] segment_drive_lines;
   wire [3:0]  ptr_q;
   wire [2:0]  iva_level_q;
   wire [31:0] pix_com0;
   wire        bias_third_q, bias_gen_on_q, reg_en_q, iva_en_q, osc_on_q, disp_on_q;
   int         mismatches = 0, compares = 0;
   lcdc_core dut_u (.mclk, .sys_rst, .external_reset_low, .cmd_ptr_load, .cmd_ptr_addr,
      .cmd_data_wr, .cmd_data, .cmd_mode_wr, .led_share_hi_bit, .led_share_lo_bit, .cmd_sys_wr,
      .cmd_osc_on, .cmd_disp_on, .cmd_bias_third, .cmd_frame_wr, .cmd_frame_sel, .cmd_blink_wr,
      .cmd_blink_sel, .cmd_reg_wr, .cmd_reg_en, .cmd_iva_en, .cmd_iva_level, .cmd_led_wr,
      .cmd_led_data, .cmd_rd, .rd_data_q, .ptr_q, .common_drive_lines, .segment_drive_lines,
      .led_sink_outputs, .bias_third_q, .bias_gen_on_q, .reg_en_q, .iva_en_q, .iva_level_q,
      .osc_on_q, .disp_on_q);
   lcdc_panel pan_u (.common_drive_lines, .segment_drive_lines, .led_sink_outputs, .led_lit,
      .pix_com0);
   initial forever #5 mclk = ~mclk;
   // One command: 0 ptr, 1 data, 2 mode, 3 sys, 4 frame, 5 blink, 6 reg, 7 led, 8 read
   task cmd(input int k, input [7:0] d);
      @(posedge mclk);
      case (k)
         0: {cmd_ptr_load, cmd_ptr_addr} <= {1'h1, d[3:0]};
         1: {cmd_data_wr, cmd_data} <= {1'h1, d};
         2: {cmd_mode_wr, led_share_hi_bit, led_share_lo_bit} <= {1'h1, d[1:0]};
         3: {cmd_sys_wr, cmd_osc_on, cmd_disp_on, cmd_bias_third} <= {1'h1, d[2:0]};
         4: {cmd_frame_wr, cmd_frame_sel} <= {1'h1, d[1:0]};
         5: {cmd_blink_wr, cmd_blink_sel} <= {1'h1, d[1:0]};
         6: {cmd_reg_wr, cmd_reg_en, cmd_iva_en, cmd_iva_level} <= {1'h1, d[4:0]};
         7: {cmd_led_wr, cmd_led_data} <= {1'h1, d};
         default: cmd_rd <= 1'h1;
      endcase
      @(posedge mclk);
      {cmd_ptr_load, cmd_data_wr, cmd_mode_wr, cmd_sys_wr, cmd_frame_wr} <= 5'h0;
      {cmd_blink_wr, cmd_reg_wr, cmd_led_wr, cmd_rd} <= 4'h0;
      #1;
   endtask
   task t_reset;
      #1;
      `CHK({bias_third_q, osc_on_q, disp_on_q, bias_gen_on_q}, 4'h8)
      `CHK({reg_en_q, iva_en_q}, 2'h1)
      `CHK(led_sink_outputs, 8'h00)
      `CHK({common_drive_lines, segment_drive_lines}, {72{1'h1}})
   endtask
   task t_mem;
      cmd(0, 8'h05);
      cmd(1, 8'hA5);
      cmd(1, 8'h3C);
      `CHK(ptr_q, 4'h7)
      cmd(0, 8'h05);
      cmd(8, 8'h00);
      `CHK(rd_data_q, 8'hA5)
      cmd(8, 8'h00);
      `CHK(rd_data_q, 8'h3C)
   endtask
   // Modes 28, 24, then 32 with the low share bit set
   task t_modes;
      for (int k = 0; k < 3; k++) begin
         cmd(2, {6'h0, 6'b101101 >> (4 - 2 * k)} & 8'h03);
         cmd(7, 8'hA5);
         cmd(0, {4'h0, 12'hDBF >> (8 - 4 * k)} & 8'h0F);
         cmd(1, 8'h00);
         `CHK(ptr_q, 4'h0)
         repeat (2) @(posedge mclk);
         #1;
         `CHK(led_lit, 8'(24'h05A500 >> (16 - 8 * k)))
      end
   endtask
   task t_disp;
      logic [31:0] exp;
      int n;
      cmd(0, 8'h00);
      for (n = 0; n < 16; n++) begin
         cmd(1, {3'h0, n[1], 3'h7, n[0]});
         exp[2*n +: 2] = n[1:0];
      end
      for (n = 0; n < 4; n++) begin
         cmd(4, n[7:0]);
         cmd(5, n[7:0]);
      end
      cmd(5, 8'h00);
      cmd(6, 8'h15);
      `CHK({reg_en_q, iva_en_q, iva_level_q}, 5'h15)
      cmd(3, 8'h02);
      repeat (4) @(posedge mclk);
      #1;
      `CHK(common_drive_lines, 8'hFF)
      `CHK(bias_third_q, 1'h0)
      cmd(3, 8'h07);
      for (n = 0; n < 20000 && common_drive_lines === 8'hFF; n++) @(posedge mclk);
      if (n >= 20000) begin
         mismatches++;
         end_of_test;
      end
      #1;
      `CHK(common_drive_lines[1] ^ common_drive_lines[0], 1'h0)
      `CHK(pix_com0, exp)
      cmd(3, 8'h05);
      cmd(0, 8'h03);
      cmd(8, 8'h00);
      `CHK(rd_data_q, 8'h1F)
   endtask
   task t_ext;
      cmd(2, 8'h03);
      cmd(3, 8'h07);
      @(posedge mclk);
      external_reset_low <= 1'h0;
      repeat (3) @(posedge mclk);
      external_reset_low <= 1'h1;
      repeat (3) @(posedge mclk);
      #1;
      `CHK({bias_third_q, osc_on_q, disp_on_q, reg_en_q}, 4'h8)
      `CHK(&{common_drive_lines, segment_drive_lines}, 1'h1)
      cmd(0, 8'h0F);
      `CHK(ptr_q, 4'hF)
   endtask
   task end_of_test;
      if (mismatches == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Power-on reset, then the scenarios in turn
   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'h0;
      t_reset;
      repeat (4) @(posedge mclk);
      t_mem;
      t_modes;
      t_disp;
      t_ext;
      end_of_test;
   end
endmodule // testbench
